// File: core/tcrc_pkg.sv
// Shared constants and types for the Type-C role and orientation controller
`default_nettype none

package tcrc_pkg;

    // Clock and mux switching time
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_SW_NS = 500;
    // Longest time rounds down, never below one cycle
    localparam int SW_CYC_RAW = T_SW_NS / CLK_PERIOD_NS;
    localparam int SW_CYC = (SW_CYC_RAW < 1) ? 1 : SW_CYC_RAW;
    localparam logic [2:0] MUX_SETTLE_LOAD = 3'(SW_CYC - 1);

    // Attach debounce and DRP toggle half period, in clock cycles
    localparam logic [9:0] DEBOUNCE_CYC = 10'h3e8;
    localparam logic [9:0] TOGGLE_CYC = 10'h1f4;
    localparam logic [9:0] TIMER_RESET = 10'h000;

    // Cycles after reset release before the strap is captured
    localparam logic [1:0] STRAP_WAIT_CYC = 2'h3;

    // Mux settle counter reset value
    localparam logic [2:0] MUX_SETTLE_RESET = 3'h0;

    // Level codes reported by the CC comparators, one per pin
    localparam logic [2:0] CC_OPEN = 3'h0;
    localparam logic [2:0] CC_RA = 3'h1;
    localparam logic [2:0] CC_RD = 3'h2;
    localparam logic [2:0] CC_RP_DEF = 3'h3;
    localparam logic [2:0] CC_RP_MID = 3'h4;
    localparam logic [2:0] CC_RP_HIGH = 3'h5;

    // Current mode codes shown to the system
    localparam logic [1:0] CUR_NONE = 2'h0;
    localparam logic [1:0] CUR_DEF = 2'h1;
    localparam logic [1:0] CUR_MID = 2'h2;
    localparam logic [1:0] CUR_HIGH = 2'h3;

    // Strapped role of the port
    typedef enum logic [1:0] {
        ROLE_SRC,
        ROLE_SNK,
        ROLE_DRP
    } tcrc_role_type;

    // True when the pin sees any source pull-up
    function automatic logic cc_is_rp(input logic [2:0] code);
        cc_is_rp = (code == CC_RP_DEF) || (code == CC_RP_MID) || (code == CC_RP_HIGH);
    endfunction

    // Current level advertised by a source pull-up
    function automatic logic [1:0] cc_rp_current(input logic [2:0] code);
        if (code == CC_RP_HIGH) begin
            cc_rp_current = CUR_HIGH;
        end else if (code == CC_RP_MID) begin
            cc_rp_current = CUR_MID;
        end else if (code == CC_RP_DEF) begin
            cc_rp_current = CUR_DEF;
        end else begin
            cc_rp_current = CUR_NONE;
        end
    endfunction

endpackage

`default_nettype wire

// File: core/tcrc_sync.sv
// Two-flop synchroniser for a bundle of pin levels
`default_nettype none

module tcrc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (rst) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule // tcrc_sync

`default_nettype wire

// File: core/tcrc_strap_latch.sv
// Captures the three-level role strap once after reset
`default_nettype none

module tcrc_strap_latch
    import tcrc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic strap_high,
    input wire logic strap_low,
    output tcrc_pkg::tcrc_role_type role,
    output logic role_valid
);

    logic [1:0] wait_cnt;
    logic [1:0] next_wait_cnt;
    tcrc_role_type next_role;
    logic next_role_valid;

    // Wait for the synchroniser to fill, then take the strap and hold it
    always_comb begin
        next_wait_cnt = wait_cnt;
        next_role = role;
        next_role_valid = role_valid;
        if (!role_valid) begin
            if (wait_cnt == STRAP_WAIT_CYC) begin
                next_role_valid = 1'b1;
                if (strap_high) begin
                    next_role = ROLE_SRC;
                end else if (strap_low) begin
                    next_role = ROLE_SNK;
                end else begin
                    next_role = ROLE_DRP;
                end
            end else begin
                next_wait_cnt = wait_cnt + 2'h1;
            end
        end
    end

    // Held until the next reset, even if the strap moves
    always_ff @(posedge clk) begin
        if (rst) begin
            wait_cnt <= 2'h0;
            role <= ROLE_DRP;
            role_valid <= 1'b0;
        end else begin
            wait_cnt <= next_wait_cnt;
            role <= next_role;
            role_valid <= next_role_valid;
        end
    end

endmodule // tcrc_strap_latch

`default_nettype wire

// File: core/tcrc_ctrl.sv
// Configuration-channel state machine, orientation and mux control
`default_nettype none

// How it works
// - Strap high means source only, low sink only, floating dual role.
// - Strap is taken once after reset and held until the next reset.
// - CC1 and CC2 levels decide attach, role, orientation and current; detach as sink follows VBUS.
// - Detected orientation drives the select of the two-lane SuperSpeed switch.
// - Orientation also leaves as a separate open-drain system output.
// - Switch path turns on and off within 0.5 us of the orientation change.
// - Advertisement and VCONN only as source; detection and VBUS only as sink.
// - No Power Delivery messaging; only terminations are used on CC.
// - Passive and charge-through audio adapters enter audio accessory mode only when strapped source only, never as dual role.
// - Direct-connect devices attach and detach like any other partner.
// - Orientation output released high for CC1, driven low for CC2.
// - Attach indicator goes low once attached as source to a sink.
module tcrc_ctrl
    import tcrc_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic CC_LOGIC_ENABLE_LOW,
    input wire logic PORT_STRAP_HIGH,
    input wire logic PORT_STRAP_LOW,
    input wire logic [2:0] CC1_LEVEL,
    input wire logic [2:0] CC2_LEVEL,
    input wire logic VBUS_DETECT,
    input wire logic [1:0] CURRENT_ADVERTISE,
    output logic PRESENT_RP,
    output logic PRESENT_RD,
    output logic [1:0] RP_ADVERTISE_LEVEL,
    output logic [1:0] CURRENT_DETECTED,
    output logic VCONN_CC1_EN,
    output logic VCONN_CC2_EN,
    output logic MUX_SEL,
    output logic MUX_EN,
    output logic DIR_OUT,
    output logic DIR_OE,
    output logic ATTACH_INDICATOR_N_OUT,
    output logic ATTACH_INDICATOR_N_OE,
    output logic ATTACHED,
    output logic AUDIO_ACCESSORY,
    output tcrc_pkg::tcrc_role_type STRAPPED_ROLE
);

    typedef enum logic [2:0] {
        ST_DISABLED,
        ST_UNATT_SRC,
        ST_UNATT_SNK,
        ST_WAIT_SRC,
        ST_WAIT_SNK,
        ST_ATT_SRC,
        ST_ATT_SNK,
        ST_AUDIO
    } tcrc_state_type;

    // Synchronised pins
    logic [11:0] pins_sync;
    logic en_low;
    logic strap_hi;
    logic strap_lo;
    logic [2:0] cc1;
    logic [2:0] cc2;
    logic vbus;
    logic [1:0] adv_req;
    tcrc_role_type role;
    logic role_valid;

    // State machine registers
    tcrc_state_type state;
    tcrc_state_type next_state;
    logic [9:0] timer;
    logic [9:0] next_timer;
    logic [5:0] cand;
    logic [5:0] next_cand;
    logic orient_cc2;
    logic next_orient_cc2;

    // Output registers
    logic [2:0] settle;
    logic [2:0] next_settle;
    logic next_present_rp;
    logic next_present_rd;
    logic [1:0] next_rp_adv;
    logic [1:0] next_cur_det;
    logic next_vconn1;
    logic next_vconn2;
    logic next_mux_en;
    logic next_dir_oe;
    logic next_ind_oe;
    logic next_attached;
    logic next_audio;

    // Decoded CC views
    logic ra1;
    logic ra2;
    logic rd1;
    logic rd2;
    logic rp1;
    logic rp2;
    logic sink_seen;
    logic audio_seen;
    logic source_seen;
    logic link_up;

    // Every level from the pins is external, so all of it is synchronised
    tcrc_sync #(
        .WIDTH(12)
    ) u_sync (
        .clk(SYS_CLK),
        .rst(RST),
        .async_in({CC_LOGIC_ENABLE_LOW, PORT_STRAP_HIGH, PORT_STRAP_LOW, CC1_LEVEL,
                   CC2_LEVEL, VBUS_DETECT, CURRENT_ADVERTISE}),
        .sync_out(pins_sync)
    );

    assign {en_low, strap_hi, strap_lo, cc1, cc2, vbus, adv_req} = pins_sync;

    tcrc_strap_latch u_strap (
        .clk(SYS_CLK),
        .rst(RST),
        .strap_high(strap_hi),
        .strap_low(strap_lo),
        .role(role),
        .role_valid(role_valid)
    );

    // Termination views; only resistor levels are read, never message traffic
    assign ra1 = (cc1 == CC_RA);
    assign ra2 = (cc2 == CC_RA);
    assign rd1 = (cc1 == CC_RD);
    assign rd2 = (cc2 == CC_RD);
    assign rp1 = cc_is_rp(cc1);
    assign rp2 = cc_is_rp(cc2);
    assign sink_seen = rd1 ^ rd2;
    // Both charge-through and passive audio adapters show Ra on both pins
    assign audio_seen = ra1 && ra2 && (role != ROLE_DRP);
    assign source_seen = rp1 ^ rp2;

    // Attach, detach, role and orientation
    always_comb begin
        next_state = state;
        next_cand = cand;
        next_orient_cc2 = orient_cc2;
        next_timer = (timer != TIMER_RESET) ? timer - 10'h001 : TIMER_RESET;
        case (state)
            ST_DISABLED: begin
                if (role_valid && !en_low) begin
                    next_state = (role == ROLE_SNK) ? ST_UNATT_SNK : ST_UNATT_SRC;
                    next_timer = TOGGLE_CYC;
                end
            end
            ST_UNATT_SRC: begin
                // Docks and plain sinks take the same path
                if (sink_seen || audio_seen) begin
                    next_state = ST_WAIT_SRC;
                    next_cand = {cc1, cc2};
                    next_timer = DEBOUNCE_CYC;
                end else if (role == ROLE_DRP && timer == TIMER_RESET) begin
                    next_state = ST_UNATT_SNK;
                    next_timer = TOGGLE_CYC;
                end
            end
            ST_UNATT_SNK: begin
                if (source_seen) begin
                    next_state = ST_WAIT_SNK;
                    next_cand = {cc1, cc2};
                    next_timer = DEBOUNCE_CYC;
                end else if (role == ROLE_DRP && timer == TIMER_RESET) begin
                    next_state = ST_UNATT_SRC;
                    next_timer = TOGGLE_CYC;
                end
            end
            ST_WAIT_SRC: begin
                // Any change restarts the search; a bouncing plug never attaches
                if ({cc1, cc2} != cand) begin
                    next_state = ST_UNATT_SRC;
                    next_timer = TOGGLE_CYC;
                end else if (timer == TIMER_RESET) begin
                    if (audio_seen) begin
                        next_state = ST_AUDIO;
                    end else begin
                        next_state = ST_ATT_SRC;
                        next_orient_cc2 = rd2;
                    end
                end
            end
            ST_WAIT_SNK: begin
                // A sink attaches only once VBUS is present
                if ({cc1, cc2} != cand) begin
                    next_state = ST_UNATT_SNK;
                    next_timer = TOGGLE_CYC;
                end else if (timer == TIMER_RESET && vbus) begin
                    next_state = ST_ATT_SNK;
                    next_orient_cc2 = rp2;
                end
            end
            ST_ATT_SRC: begin
                if (!(orient_cc2 ? rd2 : rd1)) begin
                    next_state = ST_UNATT_SRC;
                    next_timer = TOGGLE_CYC;
                end
            end
            ST_ATT_SNK: begin
                if (!vbus) begin
                    next_state = ST_UNATT_SNK;
                    next_timer = TOGGLE_CYC;
                end
            end
            ST_AUDIO: begin
                if (!(ra1 && ra2)) begin
                    next_state = ST_UNATT_SRC;
                    next_timer = TOGGLE_CYC;
                end
            end
            default: begin
                next_state = ST_DISABLED;
            end
        endcase
        // Enable pin released high parks the logic with no terminations
        if (en_low || !role_valid) begin
            next_state = ST_DISABLED;
            next_timer = TIMER_RESET;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            state <= ST_DISABLED;
            timer <= TIMER_RESET;
            cand <= 6'h00;
            orient_cc2 <= 1'b0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            cand <= next_cand;
            orient_cc2 <= next_orient_cc2;
        end
    end

    assign link_up = (state == ST_ATT_SRC) || (state == ST_ATT_SNK);

    // Output decode from the current state, registered below
    always_comb begin
        next_present_rp = (state == ST_UNATT_SRC) || (state == ST_WAIT_SRC) ||
                          (state == ST_ATT_SRC) || (state == ST_AUDIO);
        next_present_rd = (state == ST_UNATT_SNK) || (state == ST_WAIT_SNK) ||
                          (state == ST_ATT_SNK);
        next_rp_adv = next_present_rp ? adv_req : CUR_NONE;
        next_cur_det = CUR_NONE;
        if (state == ST_ATT_SNK) begin
            next_cur_det = cc_rp_current(orient_cc2 ? cc2 : cc1);
        end
        // VCONN goes to the unused pin only when it shows an Ra cable load
        next_vconn1 = (state == ST_ATT_SRC) && orient_cc2 && ra1;
        next_vconn2 = (state == ST_ATT_SRC) && !orient_cc2 && ra2;
        next_dir_oe = link_up && orient_cc2;
        next_ind_oe = (state == ST_ATT_SRC);
        next_attached = link_up || (state == ST_AUDIO);
        next_audio = (state == ST_AUDIO);
        // Path drops with the link and comes up inside the switching window
        next_settle = settle;
        next_mux_en = 1'b0;
        if (!link_up) begin
            next_settle = MUX_SETTLE_LOAD;
        end else if (settle != MUX_SETTLE_RESET) begin
            next_settle = settle - 3'h1;
        end else begin
            next_mux_en = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            settle <= MUX_SETTLE_RESET;
            PRESENT_RP <= 1'b0;
            PRESENT_RD <= 1'b0;
            RP_ADVERTISE_LEVEL <= CUR_NONE;
            CURRENT_DETECTED <= CUR_NONE;
            VCONN_CC1_EN <= 1'b0;
            VCONN_CC2_EN <= 1'b0;
            MUX_SEL <= 1'b0;
            MUX_EN <= 1'b0;
            DIR_OE <= 1'b0;
            ATTACH_INDICATOR_N_OE <= 1'b0;
            ATTACHED <= 1'b0;
            AUDIO_ACCESSORY <= 1'b0;
        end else begin
            settle <= next_settle;
            PRESENT_RP <= next_present_rp;
            PRESENT_RD <= next_present_rd;
            RP_ADVERTISE_LEVEL <= next_rp_adv;
            CURRENT_DETECTED <= next_cur_det;
            VCONN_CC1_EN <= next_vconn1;
            VCONN_CC2_EN <= next_vconn2;
            MUX_SEL <= orient_cc2;
            MUX_EN <= next_mux_en;
            DIR_OE <= next_dir_oe;
            ATTACH_INDICATOR_N_OE <= next_ind_oe;
            ATTACHED <= next_attached;
            AUDIO_ACCESSORY <= next_audio;
        end
    end

    // Open-drain pins only ever pull low
    assign DIR_OUT = 1'b0;
    assign ATTACH_INDICATOR_N_OUT = 1'b0;
    // Role is fixed for the whole session, so it needs no register here
    assign STRAPPED_ROLE = role;

endmodule // tcrc_ctrl

`default_nettype wire

// File: dv/tcrc_ctrl_assertions.sv
// Checker for the Type-C role and orientation controller ports
`default_nettype none

module tcrc_ctrl_checker
    import tcrc_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic CC_LOGIC_ENABLE_LOW,
    input wire logic PRESENT_RP,
    input wire logic PRESENT_RD,
    input wire logic [1:0] RP_ADVERTISE_LEVEL,
    input wire logic [1:0] CURRENT_DETECTED,
    input wire logic VCONN_CC1_EN,
    input wire logic VCONN_CC2_EN,
    input wire logic MUX_SEL,
    input wire logic MUX_EN,
    input wire logic DIR_OUT,
    input wire logic DIR_OE,
    input wire logic ATTACH_INDICATOR_N_OUT,
    input wire logic ATTACH_INDICATOR_N_OE,
    input wire logic ATTACHED,
    input wire logic AUDIO_ACCESSORY,
    input wire tcrc_pkg::tcrc_role_type STRAPPED_ROLE
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    // Accessories have no lanes, so only real partners count here
    sequence s_attach;
        $rose(ATTACHED) && !AUDIO_ACCESSORY;
    endsequence
    // Two sync flops, one state edge and one output edge, plus margin
    sequence s_parked;
        CC_LOGIC_ENABLE_LOW [*6];
    endsequence

    property p_mux_follow;
        ATTACHED && !AUDIO_ACCESSORY |-> MUX_SEL == DIR_OE;
    endproperty
    a_mux_follow: assert property (p_mux_follow)
        else $error("mux select differs from orientation");
    property p_switch_on;
        s_attach |-> ##[1:5] MUX_EN;
    endproperty
    a_switch_on: assert property (p_switch_on)
        else $error("switch path late after attach");
    property p_switch_off;
        $fell(ATTACHED) |-> !MUX_EN && !DIR_OE;
    endproperty
    a_switch_off: assert property (p_switch_off)
        else $error("switch path still on after detach");
    property p_indicator;
        ATTACH_INDICATOR_N_OE |-> ATTACHED && PRESENT_RP;
    endproperty
    a_indicator: assert property (p_indicator)
        else $error("attach indicator without attached source");
    property p_od_low;
        !DIR_OUT && !ATTACH_INDICATOR_N_OUT;
    endproperty
    a_od_low: assert property (p_od_low)
        else $error("open-drain output drives high");
    property p_snk_gate;
        STRAPPED_ROLE == ROLE_SNK |-> !PRESENT_RP && RP_ADVERTISE_LEVEL == CUR_NONE
            && !VCONN_CC1_EN && !VCONN_CC2_EN;
    endproperty
    a_snk_gate: assert property (p_snk_gate)
        else $error("source feature active in sink role");
    property p_src_gate;
        STRAPPED_ROLE == ROLE_SRC |-> !PRESENT_RD && CURRENT_DETECTED == CUR_NONE;
    endproperty
    a_src_gate: assert property (p_src_gate)
        else $error("sink feature active in source role");
    property p_vconn;
        VCONN_CC1_EN || VCONN_CC2_EN |-> ATTACHED && PRESENT_RP
            && !(VCONN_CC1_EN && VCONN_CC2_EN);
    endproperty
    a_vconn: assert property (p_vconn)
        else $error("VCONN outside attached source");
    property p_role_hold;
        STRAPPED_ROLE != ROLE_DRP |=> $stable(STRAPPED_ROLE);
    endproperty
    a_role_hold: assert property (p_role_hold)
        else $error("strapped role changed without reset");
    property p_disable;
        s_parked |-> !ATTACHED && !PRESENT_RP && !PRESENT_RD;
    endproperty
    a_disable: assert property (p_disable)
        else $error("logic active while disabled");
    // Lane choice only moves as a new attach is reported, never on detach
    property p_sel_hold;
        $changed(MUX_SEL) |-> $rose(ATTACHED);
    endproperty
    a_sel_hold: assert property (p_sel_hold)
        else $error("mux select moved without a new attach");
endmodule // tcrc_ctrl_checker

bind tcrc_ctrl tcrc_ctrl_checker chk_u (.SYS_CLK, .RST, .CC_LOGIC_ENABLE_LOW, .PRESENT_RP,
    .PRESENT_RD, .RP_ADVERTISE_LEVEL, .CURRENT_DETECTED, .VCONN_CC1_EN, .VCONN_CC2_EN,
    .MUX_SEL, .MUX_EN, .DIR_OUT, .DIR_OE, .ATTACH_INDICATOR_N_OUT, .ATTACH_INDICATOR_N_OE,
    .ATTACHED, .AUDIO_ACCESSORY, .STRAPPED_ROLE);

`default_nettype wire

// File: dv/tcrc_partner.sv
// Behavioural far-side partner: sink, cabled sink, source or audio adapter
`default_nettype none

module tcrc_partner
    import tcrc_pkg::*;
(
    input wire logic clk,
    input wire logic [2:0] kind,
    input wire logic flip,
    input wire logic [2:0] rp_code,
    input wire logic present_rd,
    output logic [2:0] cc1,
    output logic [2:0] cc2,
    output logic vbus
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [2:0] near;
    logic [2:0] far;

    // Kind 1 sink, 2 sink with active cable, 3 source, 4 audio adapter
    assign near = (kind == 3'h1 || kind == 3'h2) ? CC_RD :
        (kind == 3'h3) ? rp_code : (kind == 3'h4) ? CC_RA : CC_OPEN;
    assign far = (kind == 3'h2 || kind == 3'h4) ? CC_RA : CC_OPEN;

    initial begin
        cc1 = CC_OPEN;
        cc2 = CC_OPEN;
        vbus = 1'b0;
    end

    // The bench also plugs an audio adapter on a dual-role strap, where it is ignored; a source waits for Rd
    always @(posedge clk) begin
        cc1 <= flip ? far : near;
        cc2 <= flip ? near : far;
        vbus <= (kind == 3'h3) && present_rd;
    end
endmodule // tcrc_partner

`default_nettype wire

// File: dv/tcrc_ctrl_test.sv
// Self-checking bench for the Type-C role and orientation controller
`default_nettype none

module tcrc_ctrl_test
    import tcrc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic enable_low = 1'b1;
    logic strap_high = 1'b0;
    logic strap_low = 1'b0;
    logic [1:0] advertise = CUR_DEF;
    logic [2:0] kind = 3'h0;
    logic flip = 1'b0;
    logic [2:0] rp_code = CC_RP_DEF;
    logic [2:0] cc1;
    logic [2:0] cc2;
    logic vbus, present_rp, present_rd, vconn1, vconn2, mux_sel, mux_en, dir_oe;
    logic ind_oe, attached, audio;
    logic [1:0] rp_level;
    logic [1:0] cur_det;
    tcrc_role_type role;
    int num_errors = 0;
    int checked = 0;
    int hold = 20000;

    tcrc_ctrl dut_u (.SYS_CLK(sys_clk), .RST(rst), .CC_LOGIC_ENABLE_LOW(enable_low),
        .PORT_STRAP_HIGH(strap_high), .PORT_STRAP_LOW(strap_low), .CC1_LEVEL(cc1),
        .CC2_LEVEL(cc2), .VBUS_DETECT(vbus), .CURRENT_ADVERTISE(advertise),
        .PRESENT_RP(present_rp), .PRESENT_RD(present_rd), .RP_ADVERTISE_LEVEL(rp_level),
        .CURRENT_DETECTED(cur_det), .VCONN_CC1_EN(vconn1), .VCONN_CC2_EN(vconn2),
        .MUX_SEL(mux_sel), .MUX_EN(mux_en), .DIR_OUT(), .DIR_OE(dir_oe),
        .ATTACH_INDICATOR_N_OUT(), .ATTACH_INDICATOR_N_OE(ind_oe), .ATTACHED(attached),
        .AUDIO_ACCESSORY(audio), .STRAPPED_ROLE(role));

    tcrc_partner partner_u (.clk(sys_clk), .kind(kind), .flip(flip), .rp_code(rp_code),
        .present_rd(present_rd), .cc1(cc1), .cc2(cc2), .vbus(vbus));

    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
        checked++;
        if (seen !== want) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Debounce is 1000 cycles and a dual role toggle can add 500 more
    task automatic wait_attach(input logic want);
        int n;
        n = 0;
        while (attached !== want && n < 4000) begin
            @(negedge sys_clk);
            n++;
        end
        if (attached !== want) begin
            num_errors++;
            $display("ERROR attach wait expected %h seen %h", want, attached);
            print_verdict();
        end
    endtask

    task automatic plug(input logic [2:0] k, input logic f);
        @(posedge sys_clk);
        kind <= k;
        flip <= f;
    endtask

    // Strap is set while in reset and left alone until the next one
    task automatic restart(input logic h, input logic l);
        @(posedge sys_clk);
        rst <= 1'b1;
        enable_low <= 1'b1;
        strap_high <= h;
        strap_low <= l;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (hold) @(posedge sys_clk);
        hold = 20;
        enable_low <= 1'b0;
        repeat (10) @(negedge sys_clk);
    endtask

    task automatic t_source(input logic f);
        restart(1'b1, 1'b0);
        check("role", role, ROLE_SRC);
        plug(3'h2, f);
        advertise <= CUR_HIGH;
        wait_attach(1'b1);
        check("dir", dir_oe, f);
        check("sel", mux_sel, f);
        repeat (5) @(negedge sys_clk);
        check("mux on", mux_en, 1'b1);
        check("indicator", ind_oe, 1'b1);
        check("advert", rp_level, CUR_HIGH);
        check("vconn", {vconn1, vconn2}, {f, ~f});
        plug(3'h0, f);
        wait_attach(1'b0);
        check("mux off", mux_en, 1'b0);
        check("held sel", mux_sel, f);
        $display("Source test done, flip %0d", f);
    endtask

    task automatic t_sink();
        logic [2:0] codes [3] = '{CC_RP_DEF, CC_RP_MID, CC_RP_HIGH};
        logic [1:0] cur [3] = '{CUR_DEF, CUR_MID, CUR_HIGH};
        restart(1'b0, 1'b1);
        check("role", role, ROLE_SNK);
        for (int i = 0; i < 3; i++) begin
            rp_code <= codes[i];
            plug(3'h3, 1'b1);
            wait_attach(1'b1);
            check("current", cur_det, cur[i]);
            check("sel", mux_sel, 1'b1);
            check("dir", dir_oe, 1'b1);
            check("indicator", ind_oe, 1'b0);
            check("no advert", {present_rp, rp_level, vconn1, vconn2}, 8'h00);
            plug(3'h0, 1'b1);
            wait_attach(1'b0);
        end
        $display("Sink test done");
    endtask

    task automatic t_audio();
        restart(1'b1, 1'b0);
        plug(3'h4, 1'b0);
        wait_attach(1'b1);
        check("audio", audio, 1'b1);
        plug(3'h0, 1'b0);
        wait_attach(1'b0);
        check("audio off", audio, 1'b0);
        $display("Audio test done");
    endtask

    task automatic t_drp();
        restart(1'b0, 1'b0);
        check("role", role, ROLE_DRP);
        plug(3'h4, 1'b0);
        repeat (2500) @(negedge sys_clk);
        check("audio ignored", attached, 1'b0);
        plug(3'h1, 1'b0);
        wait_attach(1'b1);
        check("as source", {present_rp, ind_oe}, 2'h3);
        @(posedge sys_clk);
        enable_low <= 1'b1;
        repeat (8) @(negedge sys_clk);
        check("disabled", {attached, present_rp}, 2'h0);
        rp_code <= CC_RP_MID;
        plug(3'h3, 1'b0);
        enable_low <= 1'b0;
        wait_attach(1'b1);
        check("as sink", {present_rd, cur_det}, {1'b1, CUR_MID});
        plug(3'h0, 1'b0);
        wait_attach(1'b0);
        $display("Dual role test done");
    endtask

    initial begin
        t_source(1'b0);
        t_source(1'b1);
        t_sink();
        t_audio();
        t_drp();
        print_verdict();
    end
endmodule // tcrc_ctrl_test

`default_nettype wire
